/* core/rtu_frame_params.svh */
`ifndef RTU_FRAME_PARAMS_SVH
`define RTU_FRAME_PARAMS_SVH

/*
 Register word indices, field codes, reset values and timing counts for
 the serial frame engine. Assumes a 50 MHz system clock.
*/

`define RTU_CLK_HZ          50000000
`define RTU_BAUD_DEFAULT    9600
`define RTU_HALF_BIT_CYCLES (`RTU_CLK_HZ / (2 * `RTU_BAUD_DEFAULT))

`define RTU_IDX_CTRL        3'h0
`define RTU_IDX_BAUD        3'h1
`define RTU_IDX_STATUS      3'h2
`define RTU_IDX_RXDATA      3'h3
`define RTU_IDX_TXDATA      3'h4

`define RTU_PAR_NONE        2'h0
`define RTU_PAR_EVEN        2'h1
`define RTU_PAR_ODD         2'h2

`define RTU_RST_DATA8       1'b1
`define RTU_RST_PARITY      `RTU_PAR_EVEN
`define RTU_RST_OWN_ADDR    8'h01
`define RTU_MAX_ADDR        8'hF7
`define RTU_BCAST_ADDR      8'h00

`define RTU_FUNC_READ       8'h03
`define RTU_FUNC_WRITE      8'h06

`define RTU_CRC_PRESET      16'hFFFF
`define RTU_CRC_POLY        16'hA001
`define RTU_MIN_FRAME       8'h06

`define RTU_GAP_MULT        8'h03
`define RTU_END_MULT        8'h07

`endif

/* core/rtu_frame_pkg.sv */
/*
 Types shared by the serial frame engine: state enums and the packed
 carriers for configuration and status flags. No assumptions beyond
 a single clock domain.
*/
package rtu_frame_pkg;

	typedef enum logic [1:0] {R_IDLE, R_START, R_BITS, R_STOP} rx_state_e;
	typedef enum logic [1:0] {T_IDLE, T_WAIT, T_NEXT, T_SEND} tx_state_e;
	typedef enum logic [1:0] {PH_DATA, PH_CRC_LO, PH_CRC_HI} tx_phase_e;

	typedef struct packed {
		logic [7:0] own_addr;
		logic [1:0] parity;
		logic       data8;
	} ctrl_s;

	typedef struct packed {
		logic tx_refused;
		logic overrun;
		logic bcast;
		logic frame_ok;
		logic func_err;
		logic gap_err;
		logic short_err;
		logic crc_err;
		logic parity_err;
	} status_s;

endpackage

/* core/rtu_serial_frame_engine.sv */
/*
 Slave-side RTU framing engine: character receive/transmit, silence
 based frame delimiting, address filter and CRC-16 check/generation,
 with an Avalon-MM register slave. Assumes one clock, synchronous reset
 and an external half-duplex line driver steered by rs485_tx_en.
*/
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "rtu_frame_params.svh"

module rtu_serial_frame_engine
	import rtu_frame_pkg::*;
#(
	parameter logic [15:0] HALF_BIT_CYC = 16'(`RTU_HALF_BIT_CYCLES)
) (
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic [2:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        rs485_rx,
	output logic             rs485_tx,
	output logic             rs485_tx_en
);

	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			if (r[0])
				r = (r >> 1) ^ `RTU_CRC_POLY;
			else
				r = r >> 1;
		end
		return r;
	endfunction

	function automatic logic par_bit(input logic [7:0] d,
		input logic [1:0] mode);
		return (mode == `RTU_PAR_EVEN) ? ^d : ~^d;
	endfunction

	ctrl_s       ctrl;
	logic [15:0] half_cyc;
	status_s     sticky;
	status_s     ev;
	logic [3:0]  nd;
	logic [3:0]  char_bits;
	logic [7:0]  t15_half;
	logic [7:0]  t35_half;
	logic [15:0] full_m1;
	logic        par_on;
	logic        rx_s1, rx_s2, rx_s3, rx_f;
	rx_state_e   rx_st;
	logic [15:0] rx_cnt;
	logic [3:0]  rx_idx;
	logic [7:0]  rx_sh;
	logic        rx_pbad;
	logic        rx_stb;
	logic [7:0]  rx_byte;
	logic        rx_byte_perr;
	logic [15:0] idle_cyc;
	logic [7:0]  idle_half;
	logic        in_frame, closed, addr_hit, bcast, fr_perr;
	logic [7:0]  fr_cnt;
	logic [15:0] fr_crc;
	logic        resp_allowed;
	logic        hit_now, rx_push;
	logic [7:0]  rx_hold;
	logic        rx_first, rx_valid;
	logic        ev_parity, ev_crc, ev_short, ev_gap, ev_func;
	logic        ev_ok, ev_bcast, ev_overrun, ev_txref;
	tx_state_e   tx_st;
	tx_phase_e   ph;
	logic [11:0] tx_sh;
	logic [11:0] tx_char;
	logic [7:0]  tx_src;
	logic [3:0]  tx_left;
	logic [15:0] tx_cnt;
	logic [15:0] tx_crc;
	logic        tx_last, tx_done;
	logic        hold_valid, hold_last, hold_take;
	logic [7:0]  hold_byte, hold_m;
	logic        wr_ok, rd_ok, tx_allow;
	logic [31:0] rd_mux;

	// character geometry: parity and stop bits always total two
	always_comb begin
		par_on    = (ctrl.parity != `RTU_PAR_NONE);
		nd        = ctrl.data8 ? 4'h8 : 4'h7;
		char_bits = nd + 4'h3;
		t15_half  = {4'h0, char_bits} * `RTU_GAP_MULT;
		t35_half  = {4'h0, char_bits} * `RTU_END_MULT;
		full_m1   = {half_cyc[14:0], 1'b0} - 16'h0001;
	end

	// only the second and third stages are compared
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			rx_s3 <= 1'b1;
			rx_f  <= 1'b1;
		end else begin
			rx_s1 <= rs485_rx;
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
			if (rx_s2 == rx_s3)
				rx_f <= rx_s3;
		end
	end

	// receiver ignores its own echo while driving the line
	always_ff @(posedge clk_sys) begin
		rx_stb <= 1'b0;
		if (srst) begin
			rx_st        <= R_IDLE;
			rx_cnt       <= 16'h0000;
			rx_idx       <= 4'h0;
			rx_sh        <= 8'h00;
			rx_pbad      <= 1'b0;
			rx_byte      <= 8'h00;
			rx_byte_perr <= 1'b0;
		end else begin
			unique case (rx_st)
				R_IDLE: if (!rx_f && !rs485_tx_en) begin
					rx_st  <= R_START;
					rx_cnt <= half_cyc - 16'h0001;
				end
				R_START: if (rx_cnt == 16'h0000) begin
					if (rx_f) begin
						rx_st <= R_IDLE;
					end else begin
						rx_st   <= R_BITS;
						rx_cnt  <= full_m1;
						rx_idx  <= 4'h0;
						rx_sh   <= 8'h00;
						rx_pbad <= 1'b0;
					end
				end else begin
					rx_cnt <= rx_cnt - 16'h0001;
				end
				R_BITS: if (rx_cnt == 16'h0000) begin
					rx_cnt <= full_m1;
					rx_idx <= rx_idx + 4'h1;
					if (rx_idx < nd)
						rx_sh[rx_idx[2:0]] <= rx_f;
					else
						rx_pbad <= rx_f != par_bit(rx_sh, ctrl.parity);
					if (rx_idx == nd - 4'h1 + {3'h0, par_on})
						rx_st <= R_STOP;
				end else begin
					rx_cnt <= rx_cnt - 16'h0001;
				end
				R_STOP: if (rx_cnt == 16'h0000) begin
					// a low stop bit is not flagged; idle restarts on it
					rx_st        <= R_IDLE;
					rx_stb       <= 1'b1;
					rx_byte      <= rx_sh;
					rx_byte_perr <= rx_pbad;
				end else begin
					rx_cnt <= rx_cnt - 16'h0001;
				end
			endcase
		end
	end

	// line silence counted in half-bit units, saturating
	always_ff @(posedge clk_sys) begin
		if (srst || !rx_f || rx_st != R_IDLE || rs485_tx_en) begin
			idle_cyc  <= 16'h0000;
			idle_half <= 8'h00;
		end else if (idle_cyc == half_cyc - 16'h0001) begin
			idle_cyc <= 16'h0000;
			if (idle_half != 8'hFF)
				idle_half <= idle_half + 8'h01;
		end else begin
			idle_cyc <= idle_cyc + 16'h0001;
		end
	end

	always_comb begin
		hit_now = (rx_byte == ctrl.own_addr) ||
			(rx_byte == `RTU_BCAST_ADDR);
		rx_push = rx_stb && ((!in_frame || closed) ? hit_now : addr_hit);
	end

	// frame assembly; crc over the whole frame leaves zero when intact
	always_ff @(posedge clk_sys) begin
		ev_parity <= 1'b0;
		ev_crc    <= 1'b0;
		ev_short  <= 1'b0;
		ev_gap    <= 1'b0;
		ev_func   <= 1'b0;
		ev_ok     <= 1'b0;
		ev_bcast  <= 1'b0;
		if (srst) begin
			in_frame     <= 1'b0;
			closed       <= 1'b0;
			addr_hit     <= 1'b0;
			bcast        <= 1'b0;
			fr_perr      <= 1'b0;
			fr_cnt       <= 8'h00;
			fr_crc       <= `RTU_CRC_PRESET;
			resp_allowed <= 1'b0;
		end else begin
			if (tx_done)
				resp_allowed <= 1'b0;
			if (rx_stb) begin
				ev_parity <= rx_byte_perr;
				if (!in_frame || closed) begin
					ev_gap       <= in_frame;
					in_frame     <= 1'b1;
					closed       <= 1'b0;
					fr_cnt       <= 8'h01;
					fr_crc       <= crc_byte(`RTU_CRC_PRESET, rx_byte);
					addr_hit     <= hit_now;
					bcast        <= rx_byte == `RTU_BCAST_ADDR;
					fr_perr      <= rx_byte_perr;
					resp_allowed <= 1'b0;
				end else begin
					if (fr_cnt != 8'hFF)
						fr_cnt <= fr_cnt + 8'h01;
					fr_crc  <= crc_byte(fr_crc, rx_byte);
					fr_perr <= fr_perr | rx_byte_perr;
					if (fr_cnt == 8'h01 && addr_hit &&
						rx_byte != `RTU_FUNC_READ && rx_byte != `RTU_FUNC_WRITE)
						ev_func <= 1'b1;
				end
			end else if (in_frame && idle_half >= t35_half) begin
				in_frame <= 1'b0;
				closed   <= 1'b0;
				ev_short <= fr_cnt < `RTU_MIN_FRAME || fr_cnt[0];
				ev_crc   <= fr_crc != 16'h0000;
				if (addr_hit && !fr_perr && fr_crc == 16'h0000 &&
					fr_cnt >= `RTU_MIN_FRAME && !fr_cnt[0]) begin
					ev_ok        <= 1'b1;
					ev_bcast     <= bcast;
					resp_allowed <= !bcast;
				end
			end else if (in_frame && idle_half >= t15_half) begin
				closed <= 1'b1;
			end
		end
	end

	// single-byte receive holding register; set wins over read clear
	always_ff @(posedge clk_sys) begin
		ev_overrun <= 1'b0;
		if (srst) begin
			rx_hold  <= 8'h00;
			rx_first <= 1'b0;
			rx_valid <= 1'b0;
		end else if (rx_push) begin
			rx_hold    <= rx_byte;
			rx_first   <= !in_frame || closed;
			rx_valid   <= 1'b1;
			ev_overrun <= rx_valid && !(rd_ok &&
				avs_address == `RTU_IDX_RXDATA);
		end else if (rd_ok && avs_address == `RTU_IDX_RXDATA) begin
			rx_valid <= 1'b0;
		end
	end

	always_comb begin
		hold_m    = ctrl.data8 ? hold_byte : {1'b0, hold_byte[6:0]};
		hold_take = tx_st == T_NEXT && ph == PH_DATA && hold_valid;
		unique case (ph)
			PH_DATA:   tx_src = hold_m;
			PH_CRC_LO: tx_src = tx_crc[7:0];
			default:   tx_src = tx_crc[15:8];
		endcase
		tx_char = 12'hFFF;
		tx_char[0] = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (i < 7 || ctrl.data8)
				tx_char[i + 1] = tx_src[i];
		end
		if (par_on)
			tx_char[nd + 4'h1] = par_bit(tx_src, ctrl.parity);
	end

	// software late with the next byte stretches the frame: keep up
	always_ff @(posedge clk_sys) begin
		tx_done <= 1'b0;
		if (srst) begin
			tx_st       <= T_IDLE;
			ph          <= PH_DATA;
			tx_sh       <= 12'hFFF;
			tx_left     <= 4'h0;
			tx_cnt      <= 16'h0000;
			tx_crc      <= `RTU_CRC_PRESET;
			tx_last     <= 1'b0;
			rs485_tx    <= 1'b1;
			rs485_tx_en <= 1'b0;
		end else begin
			unique case (tx_st)
				T_IDLE: if (hold_valid) begin
					tx_st   <= T_WAIT;
					tx_last <= 1'b0;
				end
				T_WAIT: if (idle_half >= t35_half && rx_st == R_IDLE) begin
					tx_st       <= T_NEXT;
					rs485_tx_en <= 1'b1;
					tx_crc      <= `RTU_CRC_PRESET;
					ph          <= PH_DATA;
				end
				T_NEXT: if (ph != PH_DATA || hold_valid) begin
					tx_st    <= T_SEND;
					rs485_tx <= tx_char[0];
					tx_sh    <= tx_char >> 1;
					tx_left  <= char_bits - 4'h1;
					tx_cnt   <= full_m1;
					if (ph == PH_DATA) begin
						tx_crc  <= crc_byte(tx_crc, hold_m);
						tx_last <= hold_last;
					end
				end
				T_SEND: if (tx_cnt != 16'h0000) begin
					tx_cnt <= tx_cnt - 16'h0001;
				end else if (tx_left != 4'h0) begin
					rs485_tx <= tx_sh[0];
					tx_sh    <= tx_sh >> 1;
					tx_left  <= tx_left - 4'h1;
					tx_cnt   <= full_m1;
				end else begin
					unique case (ph)
						PH_DATA: begin
							tx_st <= T_NEXT;
							if (tx_last)
								ph <= PH_CRC_LO;
						end
						PH_CRC_LO: begin
							tx_st <= T_NEXT;
							ph    <= PH_CRC_HI;
						end
						default: begin
							tx_st       <= T_IDLE;
							ph          <= PH_DATA;
							rs485_tx_en <= 1'b0;
							tx_done     <= 1'b1;
						end
					endcase
				end
			endcase
		end
	end

	always_comb begin
		wr_ok    = avs_write && !avs_waitrequest;
		// clear where readdata is captured: a byte landing then survives
		rd_ok    = avs_read && avs_waitrequest;
		tx_allow = resp_allowed ||
			(tx_st != T_IDLE && ph == PH_DATA && !tx_last);
	end

	// writes to the transmit register outside a response are dropped
	always_ff @(posedge clk_sys) begin
		ev_txref <= 1'b0;
		if (srst) begin
			hold_valid <= 1'b0;
			hold_byte  <= 8'h00;
			hold_last  <= 1'b0;
		end else if (wr_ok && avs_address == `RTU_IDX_TXDATA) begin
			if (tx_allow) begin
				hold_valid <= 1'b1;
				hold_byte  <= avs_writedata[7:0];
				hold_last  <= avs_writedata[8];
			end else begin
				ev_txref <= 1'b1;
			end
		end else if (hold_take) begin
			hold_valid <= 1'b0;
		end
	end

	// format changes mid-frame corrupt the character in flight
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ctrl.data8    <= `RTU_RST_DATA8;
			ctrl.parity   <= `RTU_RST_PARITY;
			ctrl.own_addr <= `RTU_RST_OWN_ADDR;
			half_cyc      <= HALF_BIT_CYC;
		end else if (wr_ok && avs_address == `RTU_IDX_CTRL) begin
			ctrl.data8  <= avs_writedata[0];
			ctrl.parity <= avs_writedata[2:1];
			if (avs_writedata[15:8] != `RTU_BCAST_ADDR &&
				avs_writedata[15:8] <= `RTU_MAX_ADDR)
				ctrl.own_addr <= avs_writedata[15:8];
		end else if (wr_ok && avs_address == `RTU_IDX_BAUD &&
			avs_writedata[15:0] >= 16'h0002) begin
			half_cyc <= avs_writedata[15:0];
		end
	end

	always_comb begin
		ev = '{tx_refused: ev_txref, overrun: ev_overrun, bcast: ev_bcast,
			frame_ok: ev_ok, func_err: ev_func, gap_err: ev_gap,
			short_err: ev_short, crc_err: ev_crc, parity_err: ev_parity};
	end

	// write one to clear; a new event in the same cycle survives
	always_ff @(posedge clk_sys) begin
		if (srst)
			sticky <= '0;
		else if (wr_ok && avs_address == `RTU_IDX_STATUS)
			sticky <= (sticky & ~status_s'(avs_writedata[8:0])) | ev;
		else
			sticky <= sticky | ev;
	end

	always_comb begin
		unique case (avs_address)
			`RTU_IDX_CTRL:   rd_mux = {16'h0000, ctrl.own_addr, 5'h00,
				ctrl.parity, ctrl.data8};
			`RTU_IDX_BAUD:   rd_mux = {16'h0000, half_cyc};
			`RTU_IDX_STATUS: rd_mux = {21'h000000, in_frame,
				tx_st != T_IDLE, sticky};
			`RTU_IDX_RXDATA: rd_mux = {22'h000000, rx_valid, rx_first,
				rx_hold};
			`RTU_IDX_TXDATA: rd_mux = {22'h000000, resp_allowed, hold_valid,
				hold_byte};
			default:         rd_mux = 32'h00000000;
		endcase
	end

	// one wait state; transmit writes stall while the holding byte is full
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else if (avs_waitrequest && (avs_read || avs_write) &&
			!(avs_write && avs_address == `RTU_IDX_TXDATA && hold_valid)) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= rd_mux;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

endmodule

/* sim/rtu_serial_frame_engine_chk.sv */
/*
 Checker of the serial frame engine: bus handshake, line idle level,
 response framing and quiet line before a response. Bound to the
 engine; assumes one clock and a synchronous reset.
*/
`timescale 1ns/1ps
module rtu_serial_frame_engine_chk #(
	parameter logic [15:0] HALF_BIT_CYC = 16'h0A2C
) (
	input wire logic        clk_sys,
	input wire logic        srst,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        rs485_rx,
	input wire logic        rs485_tx,
	input wire logic        rs485_tx_en
);
	localparam int IDLE_MIN = 70 * int'(HALF_BIT_CYC);
	logic [31:0] idle_cnt;
	// raw line: unlike the engine's filtered view, a one-cycle low glitch restarts it
	always_ff @(posedge clk_sys) begin
		if (srst || !rs485_rx) begin
			idle_cnt <= 32'h0;
		end else if (idle_cnt != 32'hFFFFFFFF) begin
			idle_cnt <= idle_cnt + 32'h1;
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);
	a_grant_one_cycle: assert property (
		!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_read_answer: assert property (
		$rose(avs_read) |=> !avs_waitrequest)
		else $error("read not answered next cycle");
	a_grant_needs_req: assert property (
		!avs_waitrequest |-> avs_read || avs_write)
		else $error("grant without request");
	a_rdata_hold: assert property (
		avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata))
		else $error("read data moved between grants");
	a_idle_high: assert property (
		!rs485_tx_en |-> rs485_tx)
		else $error("line driven low while disabled");
	a_start_bit: assert property (
		$rose(rs485_tx_en) |=> !rs485_tx ##1 !rs485_tx)
		else $error("response lacks start bit");
	a_quiet_before_tx: assert property (
		$rose(rs485_tx_en) |-> idle_cnt >= 32'(IDLE_MIN))
		else $error("response without idle line");
	a_stop_at_drop: assert property (
		$fell(rs485_tx_en) |-> $past(rs485_tx) && $past(rs485_tx, 2))
		else $error("enable dropped before stop bit");
	a_en_holds: assert property (
		$rose(rs485_tx_en) |-> rs485_tx_en [*8])
		else $error("enable pulse too short");
endmodule
bind rtu_serial_frame_engine rtu_serial_frame_engine_chk #(
	.HALF_BIT_CYC(HALF_BIT_CYC)
) i_chk (
	.clk_sys        (clk_sys),
	.srst           (srst),
	.avs_read       (avs_read),
	.avs_write      (avs_write),
	.avs_readdata   (avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.rs485_rx       (rs485_rx),
	.rs485_tx       (rs485_tx),
	.rs485_tx_en    (rs485_tx_en)
);

/* sim/rtu_master_model.sv */
/*
 Master model for the serial line: sends frames with its own CRC and
 character format, collects response bytes. Assumes the line idles
 high and callers start on a rising clock edge.
*/
`timescale 1ns/1ps
module rtu_master_model #(
	parameter int BIT_CYC = 8
) (
	input  wire logic clk_sys,
	input  wire logic rs485_tx,
	input  wire logic rs485_tx_en,
	output logic      rs485_rx
);
	logic [1:0] par = 2'h1;
	logic [7:0] got[$];
	logic [7:0] rb;
	int         par_bad = 0;
	int         nb = 8;
	initial rs485_rx = 1'b1;
	function automatic logic [15:0] crc16(input logic [7:0] f[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (f[i]) begin
			c = c ^ {8'h00, f[i]};
			for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction
	task automatic bit_out(input logic v);
		rs485_rx <= v;
		repeat (BIT_CYC) @(posedge clk_sys);
	endtask
	// bad_p flips the parity bit on purpose
	task automatic put(input logic [7:0] b, input logic bad_p);
		bit_out(1'b0);
		for (int i = 0; i < nb; i++) bit_out(b[i]);
		// with nb of 7, bit 7 is neither sent nor counted
		if (par != 2'h0)
			bit_out(^b[6:0] ^ (nb == 8 && b[7]) ^ (par == 2'h2) ^ bad_p);
		bit_out(1'b1);
		if (par == 2'h0) bit_out(1'b1);
	endtask
	// flt[0] spoils the CRC, flt[1] the parity of byte 1
	task automatic send(input logic [7:0] f[$], input int gap,
		input logic [1:0] flt);
		logic [15:0] c;
		c = crc16(f) ^ {15'h0, flt[0]};
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
		repeat (44 * BIT_CYC) @(posedge clk_sys);
		foreach (f[i]) begin
			if (i == gap) repeat (22 * BIT_CYC) @(posedge clk_sys);
			put(f[i], flt[1] && i == 1);
		end
		repeat (44 * BIT_CYC) @(posedge clk_sys);
	endtask
	// mid-bit sampling; format follows par like the slave's setting
	initial forever begin
		@(posedge clk_sys iff (rs485_tx_en === 1'b1 &&
			rs485_tx === 1'b0));
		repeat (BIT_CYC / 2) @(posedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge clk_sys);
			rb[i] = rs485_tx;
		end
		repeat (BIT_CYC) @(posedge clk_sys);
		if (par != 2'h0 && rs485_tx !== (^rb ^ (par == 2'h2))) par_bad++;
		repeat (BIT_CYC) @(posedge clk_sys);
		got.push_back(rb);
	end
endmodule

/* sim/rtu_serial_frame_engine_tb.sv */
/*
 Testbench of the serial frame engine: registers over Avalon-MM,
 frames from the master model. Assumes a short bit time of 8 cycles.
*/
`timescale 1ns/1ps
module rtu_serial_frame_engine_tb;
	localparam logic [15:0] HALF = 16'h0004;
	logic        clk_sys = 1'b0;
	logic        srst = 1'b1;
	logic [2:0]  avs_address = 3'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        rs485_rx;
	logic        rs485_tx;
	logic        rs485_tx_en;
	int          error_cnt = 0;
	int          comparisons = 0;
	logic [7:0]  f[$];
	logic [7:0]  f_rd[$] = '{8'h01, 8'h03, 8'h00, 8'h04, 8'h00, 8'h02};
	logic [7:0]  f_rs[$] = '{8'h01, 8'h03, 8'h04, 8'h13, 8'h88, 8'h00,
		8'h00};
	always #10 clk_sys = ~clk_sys;
	rtu_serial_frame_engine #(.HALF_BIT_CYC(HALF)) i_dut (
		.clk_sys        (clk_sys),
		.srst           (srst),
		.avs_address    (avs_address),
		.avs_read       (avs_read),
		.avs_write      (avs_write),
		.avs_writedata  (avs_writedata),
		.avs_readdata   (avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.rs485_rx       (rs485_rx),
		.rs485_tx       (rs485_tx),
		.rs485_tx_en    (rs485_tx_en)
	);
	rtu_master_model #(.BIT_CYC(2 * int'(HALF))) i_mst (
		.clk_sys    (clk_sys),
		.rs485_tx   (rs485_tx),
		.rs485_tx_en(rs485_tx_en),
		.rs485_rx   (rs485_rx)
	);
	task automatic tally_and_finish();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [2:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (a != 3'h4) chk("wait states", 32'h2, n);
	endtask
	task automatic rd(input logic [2:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk($sformatf("reg %0d", a), exp, q);
	endtask
	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	// polls received bytes while the frame is on the line
	task automatic run(input logic [7:0] g[$], input int gap,
		input logic [1:0] flt, input logic [31:0] st);
		logic [7:0]  e[$];
		logic [8:0]  rx[$];
		logic [31:0] q;
		logic [15:0] c;
		bit          done;
		c = i_mst.crc16(g);
		e = g;
		e.push_back(c[7:0]);
		e.push_back(c[15:8]);
		done = 1'b0;
		fork
			begin
				i_mst.send(g, gap, flt);
				done = 1'b1;
			end
			while (!done) begin
				bus(1'b0, 3'h3, 32'h0, q);
				if (q[9] === 1'b1) rx.push_back(q[8:0]);
			end
		join
		if (st[5] && gap < 0) begin
			chk("rx count", e.size(), rx.size());
			foreach (rx[i]) chk("rx byte", {i == 0, e[i]}, rx[i]);
		end else if (g[0] > 8'h01) begin
			chk("rx count", 32'h0, rx.size());
		end
		rd(3'h2, st);
		wr(3'h2, 32'h01FF);
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		srst <= 1'b0;
		rd(3'h0, 32'h0103);
		rd(3'h2, 32'h0);
		rd(3'h7, 32'h0);
		wr(3'h1, 32'h1);
		wr(3'h7, 32'hFF);
		wr(3'h0, 32'hF803);
		rd(3'h0, 32'h0103);
		rd(3'h1, 32'h0004);
		rd(3'h7, 32'h0);
		chk("crc", 32'hCA85, i_mst.crc16(f_rd));
		run(f_rd, -1, 2'h0, 32'h20);
		rd(3'h4, 32'h0200);
		foreach (f_rs[i]) wr(3'h4, {23'h0, i == 6, f_rs[i]});
		f_rs.push_back(8'h7E);
		f_rs.push_back(8'h9D);
		for (int n = 0; n < 3000 && i_mst.got.size() < 9; n++) begin
			@(posedge clk_sys);
		end
		foreach (f_rs[i]) chk("tx byte", f_rs[i], i_mst.got[i]);
		f = f_rd;
		f[0] = 8'h00;
		run(f, -1, 2'h0, 32'h60);
		wr(3'h4, 32'h0155);
		rd(3'h2, 32'h0100);
		wr(3'h2, 32'h01FF);
		f[0] = 8'h01;
		f[1] = 8'h06;
		wr(3'h0, 32'h0102);
		i_mst.nb = 7;
		run(f_rd, -1, 2'h0, 32'h02);
		i_mst.nb = 8;
		for (int m = 0; m < 3; m++) begin
			wr(3'h0, {24'h01, 5'h0, 2'(m), 1'b1});
			i_mst.par = 2'(m);
			run(f, -1, 2'h0, 32'h20);
		end
		f[0] = 8'h02;
		run(f, -1, 2'h0, 32'h0);
		run(f_rd, -1, 2'h1, 32'h02);
		run(f_rd, -1, 2'h2, 32'h01);
		run(f_rd, 3, 2'h0, 32'h0E);
		run('{8'h01, 8'h03}, -1, 2'h0, 32'h04);
		f = f_rd;
		f.pop_back();
		run(f, -1, 2'h0, 32'h04);
		f = f_rd;
		f[1] = 8'h10;
		run(f, -1, 2'h0, 32'h30);
		chk("tx count", 32'h9, i_mst.got.size());
		chk("tx parity", 32'h0, i_mst.par_bad);
		tally_and_finish();
	end
	// the full sequence needs about 19000 cycles
	initial begin
		repeat (60000) @(posedge clk_sys);
		error_cnt++;
		tally_and_finish();
	end
endmodule
